//--- afrd_readout.v
`timescale 1ns/1ns
`default_nettype none
`include "afrd_consts.vh"
module afrd_readout (
    input  wire        clock,            // 50 MHz clock
    input  wire        rst,              // Sync reset, active high
    input  wire        power_down_n,     // Power-down, active low
    input  wire        double_rate_sel,  // Halve oversampling ratio
    input  wire [2:0]  buffer_level_sel, // Buffer level, 0 = no buffer
    input  wire [17:0] mod_sample,       // Modulator sample, signed
    input  wire        rd_n,             // Read enable, active low
    input  wire        cs_n,             // Chip select, active low
    output reg  [15:0] dout_o,           // Data output value
    output reg  [15:0] dout_oe,          // Data output enable
    output reg         data_ready_n,     // Data ready, active low
    output reg         out_of_range,     // Input beyond full scale
    output reg         data_settled,     // Settling interval elapsed
    output reg         overflow          // Buffer overrun seen
);
    ////////////////////////////////////////////////////////////////////////
    // Clip a wide sum to full-scale codes
    function [16:0] afrd_clip;
        input signed [21:0] acc;
        begin
            if (acc > $signed({6'h00, `AFRD_CODE_POS_FS})) begin
                afrd_clip = {1'b1, `AFRD_CODE_POS_FS};
            end else if (acc < $signed({6'h3F, `AFRD_CODE_NEG_FS})) begin
                afrd_clip = {1'b1, `AFRD_CODE_NEG_FS};
            end else begin
                afrd_clip = {1'b0, acc[15:0]};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Decimator: boxcar average over the oversampling ratio
    reg  [3:0]         osr_cnt_reg;
    reg  signed [21:0] acc_reg;
    reg  [15:0]        word_reg;
    reg                word_valid_reg;
    reg  [3:0]         startup_reg;
    wire [3:0]         osr;
    wire signed [21:0] acc_sum;
    wire signed [21:0] avg;
    wire [16:0]        clipped;

    assign osr = double_rate_sel ? `AFRD_OSR_DOUBLE : `AFRD_OSR_NORMAL;
    assign acc_sum = acc_reg + {{4{mod_sample[17]}}, mod_sample};
    assign avg = double_rate_sel ? (acc_sum >>> 2) : (acc_sum >>> 3);
    assign clipped = afrd_clip(avg);

    always @(posedge clock) begin
        if (rst || !power_down_n) begin
            osr_cnt_reg    <= 4'h0;
            acc_reg        <= 22'h000000;
            word_reg       <= 16'h0000;
            word_valid_reg <= 1'b0;
            out_of_range   <= 1'b0;
        end else begin
            word_valid_reg <= 1'b0;
            if (osr_cnt_reg + 4'h1 >= osr) begin
                osr_cnt_reg    <= 4'h0;
                acc_reg        <= 22'h000000;
                word_reg       <= clipped[15:0];
                word_valid_reg <= 1'b1;
                out_of_range   <= clipped[16];
            end else begin
                osr_cnt_reg <= osr_cnt_reg + 4'h1;
                acc_reg     <= acc_sum;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output buffer
    wire [15:0] fifo_data;
    wire        fifo_valid;
    wire        fifo_in_ready;
    wire [5:0]  fifo_count;
    reg         pop_reg;
    reg         rd_n_d_reg;
    wire        buffered;
    wire        read_edge;

    assign buffered  = (buffer_level_sel != 3'h0);
    // Word advances on each read release so the reader sees stable data
    assign read_edge = !rd_n_d_reg && rd_n && !cs_n;

    always @(posedge clock) begin
        if (rst) begin
            rd_n_d_reg <= 1'b1;
        end else begin
            rd_n_d_reg <= rd_n;
        end
    end

    always @* begin
        pop_reg = buffered && read_edge && fifo_valid;
    end

    afrd_fifo #(
        .WIDTH (`AFRD_DATA_W),
        .DEPTH (`AFRD_FIFO_DEPTH),
        .AW    (`AFRD_FIFO_AW)
    ) u_fifo (
        .clock     (clock),
        .rst       (rst || !buffered),
        .in_data   (word_reg),
        .in_valid  (word_valid_reg && buffered),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (pop_reg),
        .count     (fifo_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Strobe and data pins
    reg  [5:0] period_cnt_reg;
    reg  [7:0] settle_cnt_reg;
    wire [5:0] period;

    assign period = {buffer_level_sel, 3'h0};

    always @(posedge clock) begin
        if (rst) begin
            data_ready_n   <= 1'b1;
            dout_o         <= 16'h0000;
            dout_oe        <= 16'h0000;
            period_cnt_reg <= 6'h00;
            settle_cnt_reg <= 8'h00;
            data_settled   <= 1'b0;
            overflow       <= 1'b0;
            startup_reg    <= 4'h0;
        end else begin
            dout_oe <= (!rd_n && !cs_n) ? 16'hFFFF : 16'h0000;
            if (startup_reg != `AFRD_STARTUP_CLKS) begin
                // Hold off first strobe so the reader can settle
                startup_reg <= startup_reg + 4'h1;
            end
            if (word_valid_reg && buffered && !fifo_in_ready) begin
                overflow <= 1'b1;
            end
            if (!buffered) begin
                // One word per strobe, strobe low for the first clock
                if (word_valid_reg && startup_reg == `AFRD_STARTUP_CLKS) begin
                    data_ready_n <= 1'b0;
                    dout_o       <= word_reg;
                    if (settle_cnt_reg != `AFRD_SETTLE_STROBES) begin
                        settle_cnt_reg <= settle_cnt_reg + 8'h01;
                    end
                end else if (osr_cnt_reg == 4'h1) begin
                    data_ready_n <= 1'b1;
                end
            end else begin
                if (period_cnt_reg + 6'h01 >= period) begin
                    period_cnt_reg <= 6'h00;
                end else begin
                    period_cnt_reg <= period_cnt_reg + 6'h01;
                end
                if (period_cnt_reg + 6'h01 >= period
                        && {3'h0, buffer_level_sel} <= fifo_count
                        && startup_reg == `AFRD_STARTUP_CLKS) begin
                    data_ready_n <= 1'b0;
                    if (settle_cnt_reg != `AFRD_SETTLE_STROBES) begin
                        settle_cnt_reg <= settle_cnt_reg + 8'h01;
                    end
                end else if (period_cnt_reg == 6'h00) begin
                    data_ready_n <= 1'b1;
                end
                dout_o <= fifo_data;
            end
            data_settled <= (settle_cnt_reg == `AFRD_SETTLE_STROBES);
        end
    end
endmodule
`default_nettype wire

//--- afrd_consts.vh
`ifndef AFRD_CONSTS_VH
`define AFRD_CONSTS_VH

`define AFRD_DATA_W        16
`define AFRD_OSR_NORMAL    4'h8
`define AFRD_OSR_DOUBLE    4'h4
`define AFRD_CODE_POS_FS   16'h7FFF
`define AFRD_CODE_NEG_FS   16'h8000
`define AFRD_LEV_W         3
`define AFRD_FIFO_DEPTH    32
`define AFRD_FIFO_AW       5
`define AFRD_STARTUP_CLKS  4'h8
`define AFRD_SETTLE_STROBES 8'h2F
`define AFRD_CLK_PERIOD_NS 20

`endif

//--- afrd_fifo.v
`timescale 1ns/1ns
`default_nettype none
module afrd_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clock,     // System clock
    input  wire             rst,       // Sync reset, active high
    input  wire [WIDTH-1:0] in_data,   // Write data
    input  wire             in_valid,  // Write request
    output wire             in_ready,  // Space available
    output wire [WIDTH-1:0] out_data,  // Head word
    output wire             out_valid, // Word available
    input  wire             out_ready, // Drain request
    output wire [AW:0]      count      // Words held
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;
    localparam [AW:0] FULL_COUNT = DEPTH;

    assign in_ready  = (count_reg != FULL_COUNT);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_reg];
    assign count     = count_reg;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clock) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- afrd_readout_sva.sv
`timescale 1ns/1ns
`default_nettype none
module afrd_sva (
    input wire        clock,            // Clock
    input wire        rst,              // Reset
    input wire        power_down_n,     // Power-down
    input wire        double_rate_sel,  // Rate
    input wire [2:0]  buffer_level_sel, // Level
    input wire        rd_n,             // Read
    input wire        cs_n,             // Select
    input wire [15:0] dout_o,           // Data
    input wire [15:0] dout_oe,          // Enable
    input wire        data_ready_n,     // Strobe
    input wire        out_of_range,     // Clip flag
    input wire        data_settled,     // Settled
    input wire        overflow          // Overrun
);
    reg  [7:0] gap_reg;
    reg  [7:0] nf_reg;
    reg        prv_reg;
    wire       fall = prv_reg && !data_ready_n;
    wire [7:0] per = (buffer_level_sel != 3'h0) ?
                     {2'h0, buffer_level_sel, 3'h0} :
                     (double_rate_sel ? 8'h04 : 8'h08);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    always @(posedge clock) begin
        prv_reg <= data_ready_n;
        gap_reg <= fall ? 8'h01 : gap_reg + 8'h01;
        if (rst)
            nf_reg <= 8'h00;
        else if (fall && nf_reg != 8'hFF)
            nf_reg <= nf_reg + 8'h01;
    end
    rst_out_a:
        assert property (disable iff (1'b0) rst |=> data_ready_n &&
            dout_o == 16'h0000 && dout_oe == 16'h0000) else $error("reset");
    hiz_idle_a:
        assert property (rd_n || cs_n |=> dout_oe == 16'h0000)
        else $error("driven while idle");
    drive_sel_a:
        assert property (!rd_n && !cs_n |=> dout_oe == 16'hFFFF)
        else $error("not driven");
    strobe_period_a:
        assert property (fall && nf_reg != 8'h00 |-> gap_reg == per)
        else $error("strobe period");
    settle_gate_a:
        assert property (nf_reg < 8'h2E |-> !data_settled)
        else $error("settled early");
    pd_quiet_a:
        assert property (!power_down_n |-> data_ready_n)
        else $error("strobe in power-down");
    clip_code_a:
        assert property (fall && buffer_level_sel == 3'h0 && out_of_range
            |-> dout_o == 16'h7FFF || dout_o == 16'h8000) else $error("clip");
    start_hold_a:
        assert property ($fell(rst) |-> data_ready_n [*8])
        else $error("early strobe");
    ovf_sticky_a:
        assert property (overflow |=> overflow) else $error("overflow lost");
endmodule
bind afrd_readout afrd_sva chk_u (.*);
`default_nettype wire

//--- afrd_reader.sv
`timescale 1ns/1ns
`default_nettype none
module afrd_reader (
    input  wire logic        clock,            // Clock
    input  wire logic        rst,              // Reset
    input  wire logic [2:0]  buffer_level_sel, // Words per strobe
    input  wire logic        data_ready_n,     // Strobe
    input  wire logic [15:0] dout_o,           // Data
    input  wire logic [15:0] dout_oe,          // Enable
    output logic             rd_n,             // Read
    output logic             cs_n,             // Select
    output logic             busy,             // Burst running
    output logic      [15:0] got,              // Last word
    output logic      [15:0] n_rd,             // Reads done
    output logic      [15:0] n_str             // Strobes seen
);
    integer hold;
    integer i;
    logic   prv;
    initial begin
        rd_n = 1'b1;
        cs_n = 1'b1;
        busy = 1'b0;
        got = 16'h0000;
        forever begin
            @(posedge clock);
            #1;
            if (rst) begin
                rd_n = 1'b1;
                cs_n = 1'b1;
                hold = 8;
                n_rd = 16'h0000;
                n_str = 16'h0000;
            end else if (hold > 0) begin
                hold = hold - 1;
            end else begin
                // Unbuffered reader keeps both lines low
                if (buffer_level_sel == 3'h0) begin
                    cs_n = 1'b0;
                    rd_n = 1'b0;
                end
                if (prv && !data_ready_n) begin
                    n_str = n_str + 16'h0001;
                    got = (dout_oe === 16'hFFFF) ? dout_o : 16'hXXXX;
                    busy = 1'b1;
                    for (i = 0; i < buffer_level_sel; i++) begin
                        cs_n = 1'b0;
                        rd_n = 1'b0;
                        repeat (2) @(posedge clock);
                        #1;
                        got = (dout_oe === 16'hFFFF) ? dout_o : 16'hXXXX;
                        rd_n = 1'b1;
                        @(posedge clock);
                        #1;
                        cs_n = 1'b1;
                        n_rd = n_rd + 16'h0001;
                        // Gap keeps a release visible before next read
                        @(posedge clock);
                        #1;
                    end
                    busy = 1'b0;
                end
            end
            prv = data_ready_n;
        end
    end
endmodule
`default_nettype wire

//--- tb_adc_fifo_parallel_readout.sv
`timescale 1ns/1ns
`default_nettype none
module tb_adc_fifo_parallel_readout;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        power_down_n = 1'b1;
    logic        double_rate_sel = 1'b0;
    logic [2:0]  buffer_level_sel = 3'h0;
    logic [17:0] mod_sample = 18'h00000;
    logic        rd_n, cs_n, data_ready_n, out_of_range;
    logic        data_settled, overflow, busy;
    logic [15:0] dout_o, dout_oe, got, n_rd, n_str;
    integer      errors = 0;
    integer      n_tests = 0;
    integer      t;
    always #10 clock = ~clock;
    afrd_readout dut_u (.*);
    afrd_reader  rdr_u (.*);
    ////////////////////////////////////////////////////////////////////////
    function logic [15:0] exp_code(input logic signed [17:0] s);
        if (s > 18'sd32767)
            return 16'h7FFF;
        if (s < -18'sd32768)
            return 16'h8000;
        return s[15:0];
    endfunction
    task automatic check(input logic [15:0] a, input logic [15:0] e);
        n_tests++;
        if (a !== e) begin
            errors++;
            $display("Error %0t: got %h want %h", $time, a, e);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic run(input logic [2:0] lv, input logic dbl,
                       input logic pd, input logic [17:0] s);
        @(posedge clock);
        #1;
        rst = 1'b1;
        buffer_level_sel = lv;
        double_rate_sel = dbl;
        power_down_n = pd;
        mod_sample = s;
        repeat (8) @(posedge clock);
        // A burst begun before reset must end so the reader sees reset
        while (busy)
            @(posedge clock);
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        repeat (3000) @(posedge clock);
        // Look between edges so a burst starting now is not half-counted
        @(negedge clock);
        while (busy)
            @(negedge clock);
        if (!pd) begin
            check(n_str, 16'h0000);
            check({15'h0, data_settled}, 16'h0000);
        end else begin
            check(got, exp_code(s));
            check({15'h0, out_of_range}, {15'h0, exp_code(s) != s[15:0]});
            check(n_rd, n_str * {13'h0, lv});
            check({15'h0, overflow}, {15'h0, dbl && lv != 3'h0});
            check({15'h0, data_settled}, 16'h0001);
        end
        $display("test lvl %0d dbl %0d pd %0d done", lv, dbl, pd);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        t = $urandom(57);
        run(3'h0, 1'b0, 1'b1, 18'h1FFFF);
        run(3'h0, 1'b1, 1'b1, 18'h20000);
        run(3'h7, 1'b0, 1'b1, 18'h08000);
        for (t = 0; t < 8; t++)
            run(t[2:0], 1'($urandom % 2), 1'b1,
                18'($urandom_range(65535)) - 18'h08000);
        run(3'h2, 1'b0, 1'b0, 18'h00100);
        report_and_stop();
    end
    initial begin
        // Twelve runs of about 3010 clocks each, with margin
        #(45000 * 20);
        errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
